// File: inc/smcl_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef SMCL_REGS_SVH
`define SMCL_REGS_SVH

// Register indices (byte address is four times the index)
`define SMCL_IDX_BRIDGE_CONTROL 10'h04f
`define SMCL_IDX_FEATURE_CFG 10'h054
`define SMCL_IDX_LINK_CONTROL 10'h05b
`define SMCL_IDX_REMOTE_ADDR 10'h060
`define SMCL_IDX_STATUS 10'h061

// Field positions
`define SMCL_BIT_DISPLAY_ID_SOURCE 0
`define SMCL_BIT_AUX_AUDIO 1
`define SMCL_BIT_REMOTE_COPY 5
`define SMCL_BIT_EXTERNAL_CONTROL_BIT 7
`define SMCL_BIT_CABLE_MEDIUM 7
`define SMCL_BIT_PLL_RESET_FREQ 5

// Reset values
`define SMCL_RST_REMOTE_ADDR 8'ha0
`define SMCL_RST_PLL_RESET_FREQ 1'b1

// Timing
`define SMCL_CLK_PERIOD_NS 50
`define SMCL_SETTLE_NS 10000
`define SMCL_SETTLE_CYC ((`SMCL_SETTLE_NS + `SMCL_CLK_PERIOD_NS - 1) / `SMCL_CLK_PERIOD_NS)

// Level decision points on an 8-bit ratio code (full scale is the 1.8 V rail)
`define SMCL_THR_1 8'h1b
`define SMCL_THR_2 8'h44
`define SMCL_THR_3 8'h61
`define SMCL_THR_4 8'h7f
`define SMCL_THR_5 8'h9c
`define SMCL_THR_6 8'hba
`define SMCL_THR_7 8'he4

// Bus address strap
`define SMCL_BUS_ADDR_BASE 7'h0c

// Pixel clock limits in kHz
`define SMCL_PCLK_MAX_NEW_KHZ 17'h17700
`define SMCL_PCLK_MAX_OLD_KHZ 17'h14c08

// Bus responses
`define SMCL_RESP_OKAY 2'h0
`define SMCL_RESP_SLVERR 2'h2

`endif

// File: inc/smcl_pkg.sv
// Types for the strap configuration loader
package smcl_pkg;

  typedef enum logic [1:0] {
    SMCL_ST_SETTLE = 2'b00,
    SMCL_ST_SAMPLE = 2'b01,
    SMCL_ST_DONE = 2'b10
  } smcl_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } smcl_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } smcl_axi_s2m_t;

  typedef struct packed {
    logic display_id_source;
    logic aux_audio;
    logic external_control_bit;
    logic cable_cable_medium_select;
    logic remote_copy;
    logic pll_reset_freq;
    logic [7:0] remote_addr;
  } smcl_cfg_t;

  typedef struct packed {
    logic [2:0][7:0] s1;
    logic [2:0][7:0] s2;
    logic [2:0][7:0] s3;
    smcl_fsm_t fsm;
    logic [7:0] settle_cnt;
    smcl_cfg_t cfg;
    logic [1:0] mode0_lvl;
    logic [2:0] mode1_lvl;
    logic [2:0] addr_lvl;
    logic [6:0] bus_addr;
    logic aw_got;
    logic [9:0] aw_idx;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic use_remote;
    logic use_sram;
    logic use_local;
    logic copy_go;
    logic pll_reset;
    logic pclk_over;
  } smcl_state_t;

endpackage

// File: core/smcl_loader.sv
// Strap sampling, configuration bits and AXI4-Lite register slave
//
// Operation
// - Sample all three straps once after power-up
// - Source 0: remote table, else SRAM
// - Audio bit: HDMI only or HDMI plus aux
// - Override bit hands control to external controller
// - Cable bit: twisted pair or cable_medium_select
// - Copy bit copies remote table into SRAM
// - First strap: four levels give source, audio
// - Second strap: eight levels give three bits
// - Audio, override, copy bits in 0x54
// - Source in 0x4F[0], cable in 0x5B[7]
// - Newer receivers allow pixel clock to 96 MHz
// - PLL reset on frequency change while enabled
// - Address strap selects one of eight addresses
// - Addresses step by two from 0x0C
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "smcl_regs.svh"

module smcl_loader
  import smcl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_mode_sel0_ratio,
  input wire logic [7:0] i_mode_sel1_ratio,
  input wire logic [7:0] i_addr_strap_ratio,
  input wire logic i_remote_table_found,
  input wire logic i_rx_newgen,
  input wire logic [16:0] i_pclk_khz,
  input wire logic i_freq_change_det,
  input wire smcl_axi_m2s_t i_axi,
  output smcl_axi_s2m_t o_axi,
  output logic o_cfg_valid,
  output smcl_cfg_t o_cfg,
  output logic [6:0] o_bus_address,
  output logic o_use_remote_table,
  output logic o_use_internal_sram,
  output logic o_use_external_local,
  output logic o_copy_remote_to_sram,
  output logic o_pll_reset,
  output logic o_pclk_over_limit
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Nearest of eight ratio levels
  function automatic logic [2:0] lvl8(input logic [7:0] code);
    logic [2:0] n;
    n = 3'h0;
    if (code > `SMCL_THR_1) n = 3'h1;
    if (code > `SMCL_THR_2) n = 3'h2;
    if (code > `SMCL_THR_3) n = 3'h3;
    if (code > `SMCL_THR_4) n = 3'h4;
    if (code > `SMCL_THR_5) n = 3'h5;
    if (code > `SMCL_THR_6) n = 3'h6;
    if (code > `SMCL_THR_7) n = 3'h7;
    return n;
  endfunction

  // First strap uses levels 0, 1, 4, 5 only
  function automatic logic [1:0] lvl4(input logic [7:0] code);
    logic [1:0] n;
    n = 2'h0;
    if (code > `SMCL_THR_1) n = 2'h1;
    if (code > `SMCL_THR_3) n = 2'h2;
    if (code > `SMCL_THR_5) n = 2'h3;
    return n;
  endfunction

  function automatic logic [31:0] rd_word(input logic [9:0] idx, input smcl_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      `SMCL_IDX_BRIDGE_CONTROL: begin
        w[`SMCL_BIT_DISPLAY_ID_SOURCE] = s.cfg.display_id_source;
      end
      `SMCL_IDX_FEATURE_CFG: begin
        w[`SMCL_BIT_AUX_AUDIO] = s.cfg.aux_audio;
        w[`SMCL_BIT_REMOTE_COPY] = s.cfg.remote_copy;
        w[`SMCL_BIT_EXTERNAL_CONTROL_BIT] = s.cfg.external_control_bit;
      end
      `SMCL_IDX_LINK_CONTROL: begin
        w[`SMCL_BIT_CABLE_MEDIUM] = s.cfg.cable_cable_medium_select;
        w[`SMCL_BIT_PLL_RESET_FREQ] = s.cfg.pll_reset_freq;
      end
      `SMCL_IDX_REMOTE_ADDR: begin
        w[7:0] = s.cfg.remote_addr;
      end
      `SMCL_IDX_STATUS: begin
        w[0] = (s.fsm == SMCL_ST_DONE);
        w[2:1] = s.mode0_lvl;
        w[6:4] = s.mode1_lvl;
        w[10:8] = s.addr_lvl;
        w[22:16] = s.bus_addr;
        w[24] = s.pclk_over;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  function automatic logic idx_mapped(input logic [9:0] idx);
    return (idx == `SMCL_IDX_BRIDGE_CONTROL) || (idx == `SMCL_IDX_FEATURE_CFG) ||
           (idx == `SMCL_IDX_LINK_CONTROL) || (idx == `SMCL_IDX_REMOTE_ADDR) ||
           (idx == `SMCL_IDX_STATUS);
  endfunction

  localparam logic [7:0] SETTLE_LAST = 8'(`SMCL_SETTLE_CYC - 1);

  smcl_state_t q;
  smcl_state_t d;
  logic straps_stable;
  logic wr_fire;
  logic ar_fire;
  logic [9:0] wr_idx;

  assign o_axi.awready = !q.aw_got && !q.bvalid;
  assign o_axi.wready = !q.w_got && !q.bvalid;
  assign o_axi.bvalid = q.bvalid;
  assign o_axi.bresp = q.bresp;
  assign o_axi.arready = !q.rvalid;
  assign o_axi.rvalid = q.rvalid;
  assign o_axi.rdata = q.rdata;
  assign o_axi.rresp = q.rresp;

  // Straps count as stable once the second and third stages agree
  assign straps_stable = (q.s2 == q.s3);

  always_comb begin
    logic aw_now;
    logic w_now;
    logic [1:0] m0_lvl;
    logic [2:0] m1_lvl;
    logic [2:0] a_lvl;
    aw_now = i_axi.awvalid && o_axi.awready;
    w_now = i_axi.wvalid && o_axi.wready;
    m0_lvl = lvl4(q.s3[0]);
    m1_lvl = lvl8(q.s3[1]);
    a_lvl = lvl8(q.s3[2]);
    d = q;
    // -------------------------------------------------------------
    // Strap synchronisers
    // -------------------------------------------------------------
    d.s1 = {i_addr_strap_ratio, i_mode_sel1_ratio, i_mode_sel0_ratio};
    d.s2 = q.s1;
    d.s3 = q.s2;

    // -------------------------------------------------------------
    // AXI4-Lite write
    // -------------------------------------------------------------
    if (aw_now) begin
      d.aw_got = 1'b1;
      d.aw_idx = i_axi.awaddr[11:2];
    end
    if (w_now) begin
      d.w_got = 1'b1;
      d.wdata = i_axi.wdata[7:0];
      d.wstrb0 = i_axi.wstrb[0];
    end
    wr_idx = aw_now ? i_axi.awaddr[11:2] : q.aw_idx;
    wr_fire = (q.aw_got || aw_now) && (q.w_got || w_now) && !q.bvalid;
    if (wr_fire) begin
      logic [7:0] wv;
      wv = w_now ? i_axi.wdata[7:0] : q.wdata;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = idx_mapped(wr_idx) ? `SMCL_RESP_OKAY : `SMCL_RESP_SLVERR;
      if (w_now ? i_axi.wstrb[0] : q.wstrb0) begin
        case (wr_idx)
          `SMCL_IDX_BRIDGE_CONTROL: begin
            d.cfg.display_id_source = wv[`SMCL_BIT_DISPLAY_ID_SOURCE];
          end
          `SMCL_IDX_FEATURE_CFG: begin
            d.cfg.aux_audio = wv[`SMCL_BIT_AUX_AUDIO];
            d.cfg.remote_copy = wv[`SMCL_BIT_REMOTE_COPY];
            d.cfg.external_control_bit = wv[`SMCL_BIT_EXTERNAL_CONTROL_BIT];
          end
          `SMCL_IDX_LINK_CONTROL: begin
            d.cfg.cable_cable_medium_select = wv[`SMCL_BIT_CABLE_MEDIUM];
            d.cfg.pll_reset_freq = wv[`SMCL_BIT_PLL_RESET_FREQ];
          end
          `SMCL_IDX_REMOTE_ADDR: begin
            d.cfg.remote_addr = wv;
          end
          default: begin
          end
        endcase
      end
    end
    if (q.bvalid && i_axi.bready) begin
      d.bvalid = 1'b0;
    end

    // -------------------------------------------------------------
    // AXI4-Lite read
    // -------------------------------------------------------------
    ar_fire = i_axi.arvalid && o_axi.arready;
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rdata = rd_word(i_axi.araddr[11:2], q);
      d.rresp = idx_mapped(i_axi.araddr[11:2]) ? `SMCL_RESP_OKAY : `SMCL_RESP_SLVERR;
    end else if (q.rvalid && i_axi.rready) begin
      d.rvalid = 1'b0;
    end

    // -------------------------------------------------------------
    // Power-up strap sampling
    // -------------------------------------------------------------
    case (q.fsm)
      SMCL_ST_SETTLE: begin
        if (q.settle_cnt == SETTLE_LAST) begin
          d.fsm = SMCL_ST_SAMPLE;
        end else begin
          d.settle_cnt = q.settle_cnt + 8'h01;
        end
      end
      SMCL_ST_SAMPLE: begin
        if (straps_stable) begin
          d.fsm = SMCL_ST_DONE;
          d.mode0_lvl = m0_lvl;
          d.mode1_lvl = m1_lvl;
          d.addr_lvl = a_lvl;
          d.bus_addr = `SMCL_BUS_ADDR_BASE + {3'h0, a_lvl, 1'b0};
          d.cfg.display_id_source = m0_lvl[1];
          d.cfg.aux_audio = m0_lvl[0];
          d.cfg.external_control_bit = m1_lvl[2];
          d.cfg.cable_cable_medium_select = m1_lvl[1];
          d.cfg.remote_copy = m1_lvl[0];
        end
      end
      SMCL_ST_DONE: begin
        d.fsm = SMCL_ST_DONE;
      end
      default: begin
        d.fsm = SMCL_ST_SETTLE;
      end
    endcase

    // -------------------------------------------------------------
    // Settings acting on the block
    // -------------------------------------------------------------
    d.use_local = (q.fsm == SMCL_ST_DONE) && q.cfg.display_id_source;
    d.use_remote = (q.fsm == SMCL_ST_DONE) && !q.cfg.display_id_source &&
                   i_remote_table_found;
    d.use_sram = (q.fsm == SMCL_ST_DONE) && !q.cfg.display_id_source &&
                 !i_remote_table_found;
    d.copy_go = (q.fsm == SMCL_ST_DONE) && q.cfg.remote_copy &&
                i_remote_table_found;
    d.pll_reset = i_freq_change_det && q.cfg.pll_reset_freq;
    d.pclk_over = i_rx_newgen ? (i_pclk_khz > `SMCL_PCLK_MAX_NEW_KHZ) :
                  (i_pclk_khz >= `SMCL_PCLK_MAX_OLD_KHZ);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.fsm <= SMCL_ST_SETTLE;
      q.cfg.pll_reset_freq <= `SMCL_RST_PLL_RESET_FREQ;
      q.cfg.remote_addr <= `SMCL_RST_REMOTE_ADDR;
      q.bus_addr <= `SMCL_BUS_ADDR_BASE;
    end else begin
      q <= d;
    end
  end

  assign o_cfg_valid = (q.fsm == SMCL_ST_DONE);
  assign o_cfg = q.cfg;
  assign o_bus_address = q.bus_addr;
  assign o_use_remote_table = q.use_remote;
  assign o_use_internal_sram = q.use_sram;
  assign o_use_external_local = q.use_local;
  assign o_copy_remote_to_sram = q.copy_go;
  assign o_pll_reset = q.pll_reset;
  assign o_pclk_over_limit = q.pclk_over;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  strap_once_a: assert property (
    q.fsm == SMCL_ST_DONE |=> q.fsm == SMCL_ST_DONE)
    else $error("strap sampling ran again");

  mode0_latch_a: assert property (
    $rose(o_cfg_valid) |->
      o_cfg.display_id_source == ($past(q.s3[0]) > `SMCL_THR_3) &&
      o_cfg.aux_audio == (($past(q.s3[0]) > `SMCL_THR_1 && $past(q.s3[0]) <= `SMCL_THR_3) ||
                          $past(q.s3[0]) > `SMCL_THR_5))
    else $error("first strap bits not latched");

  mode1_latch_a: assert property (
    $rose(o_cfg_valid) |->
      o_cfg.external_control_bit == ($past(q.s3[1]) > `SMCL_THR_4) &&
      {o_cfg.external_control_bit, o_cfg.cable_cable_medium_select, o_cfg.remote_copy} == q.mode1_lvl)
    else $error("second strap bits not latched");

  bus_addr_a: assert property (
    o_cfg_valid |-> o_bus_address == `SMCL_BUS_ADDR_BASE + {3'h0, q.addr_lvl, 1'b0})
    else $error("bus address does not match strap level");

  bits_hold_a: assert property (
    o_cfg_valid && !wr_fire |=> $stable(o_cfg))
    else $error("settings changed without a write");

  id_source_a: assert property (
    o_cfg_valid && !o_cfg.display_id_source && !i_remote_table_found &&
    !wr_fire |=> o_use_internal_sram && !o_use_remote_table)
    else $error("no fallback to internal table");

  copy_gate_a: assert property (
    o_copy_remote_to_sram |-> $past(q.cfg.remote_copy) && $past(i_remote_table_found))
    else $error("table copy without enable or remote table");

  pll_fire_a: assert property (
    i_freq_change_det |=> o_pll_reset == $past(q.cfg.pll_reset_freq))
    else $error("pll reset does not follow enable");

  pclk_new_a: assert property (
    i_rx_newgen && i_pclk_khz <= `SMCL_PCLK_MAX_NEW_KHZ |=> !o_pclk_over_limit)
    else $error("pixel clock flagged within newer limit");

  write_resp_a: assert property (
    wr_fire |=> o_axi.bvalid && !o_axi.awready && !o_axi.wready)
    else $error("write response missing");

  read_resp_a: assert property (
    ar_fire |=> o_axi.rvalid && !o_axi.arready && o_axi.rdata[31:25] == 7'h00)
    else $error("read response missing");

endmodule

`default_nettype wire

// File: tb/smcl_strap_board.sv
// Board strap dividers feeding the three ratio inputs
`timescale 1ns/100ps
`default_nettype none

module smcl_strap_board (
  input wire logic [2:0] i_lvl0,
  input wire logic [2:0] i_lvl1,
  input wire logic [2:0] i_lvla,
  output logic [7:0] o_ratio0,
  output logic [7:0] o_ratio1,
  output logic [7:0] o_ratioa
);
  // Divider ratio of each level as a code of the 1.8 V rail
  localparam logic [7:0] LVL [8] = '{8'h00, 8'h35, 8'h52, 8'h70, 8'h8d, 8'haa, 8'hc9, 8'hff};
  assign o_ratio0 = LVL[i_lvl0];
  assign o_ratio1 = LVL[i_lvl1];
  assign o_ratioa = LVL[i_lvla];
endmodule

`default_nettype wire

// File: tb/test_smcl_loader.sv
// Self-checking bench for the strap configuration loader
`timescale 1ns/100ps
`default_nettype none
`include "smcl_regs.svh"

module test_smcl_loader
  import smcl_pkg::*;
;
  logic clk_sys, rst_n, found, newgen, fdet;
  logic [16:0] pclk;
  logic [2:0] lv0, lv1, lva;
  logic [7:0] r0, r1, ra;
  smcl_axi_m2s_t m;
  smcl_axi_s2m_t s;
  smcl_cfg_t cfg;
  logic cfg_valid, use_rem, use_sram, use_loc, copy, pll_rst, over;
  logic [3:0] strb;
  logic [6:0] bus_addr;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_mismatch, check_count;

  smcl_strap_board smcl_strap_board_i (.i_lvl0(lv0), .i_lvl1(lv1), .i_lvla(lva),
    .o_ratio0(r0), .o_ratio1(r1), .o_ratioa(ra));

  smcl_loader smcl_loader_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_mode_sel0_ratio(r0),
    .i_mode_sel1_ratio(r1), .i_addr_strap_ratio(ra), .i_remote_table_found(found),
    .i_rx_newgen(newgen), .i_pclk_khz(pclk), .i_freq_change_det(fdet), .i_axi(m),
    .o_axi(s), .o_cfg_valid(cfg_valid), .o_cfg(cfg), .o_bus_address(bus_addr),
    .o_use_remote_table(use_rem), .o_use_internal_sram(use_sram),
    .o_use_external_local(use_loc),
    .o_copy_remote_to_sram(copy), .o_pll_reset(pll_rst), .o_pclk_over_limit(over));

  always #25 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    m.awaddr <= {idx, 2'b00};
    m.wdata <= {24'h0, d};
    m.wstrb <= strb;
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s.awready === 1'b1) begin
        aw = 1'b1;
        m.awvalid <= 1'b0;
      end
      if (!w && s.wready === 1'b1) begin
        w = 1'b1;
        m.wvalid <= 1'b0;
      end
    end
    while (s.bvalid !== 1'b1) @(posedge clk_sys);
    r = s.bresp;
    m.bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    m.araddr <= {idx, 2'b00};
    m.arvalid <= 1'b1;
    m.rready <= 1'b1;
    do @(posedge clk_sys); while (s.arready !== 1'b1);
    m.arvalid <= 1'b0;
    while (s.rvalid !== 1'b1) @(posedge clk_sys);
    d = s.rdata;
    r = s.rresp;
    m.rready <= 1'b0;
  endtask

  task automatic do_reset();
    int i;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 400 && cfg_valid !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_straps();
    int k;
    logic [1:0] lv;
    for (k = 0; k < 8; k++) begin
      lv = k[1:0];
      lv0 <= {lv[1], 1'b0, lv[0]};
      lv1 <= k[2:0];
      lva <= 3'd7 - k[2:0];
      found <= k[0] ^ k[2];
      do_reset();
      chk(cfg_valid, 1);
      chk({cfg.display_id_source, cfg.aux_audio}, lv);
      chk({cfg.external_control_bit, cfg.cable_cable_medium_select, cfg.remote_copy}, k);
      chk(bus_addr, 32'h0c + 2 * (7 - k));
      chk(use_loc, lv[1]);
      chk(use_rem, !lv[1] && (k[0] ^ k[2]));
      chk(use_sram, !lv[1] && !(k[0] ^ k[2]));
      chk(copy, k[0] && (k[0] ^ k[2]));
      axi_read(`SMCL_IDX_STATUS, rd, rsp);
      chk(rd & 32'h007f0777, ((32'h0c + 2 * (7 - k)) << 16) | ((7 - k) << 8) | (k << 4)
          | (lv << 1) | 1);
      lv1 <= ~k[2:0];
      repeat (8) @(posedge clk_sys);
      chk({cfg.external_control_bit, cfg.cable_cable_medium_select, cfg.remote_copy}, k);
    end
    $display("test straps done");
  endtask

  task automatic t_regs();
    axi_read(`SMCL_IDX_REMOTE_ADDR, rd, rsp);
    chk(rd, 32'ha0);
    axi_read(`SMCL_IDX_LINK_CONTROL, rd, rsp);
    chk({rd[7], rd[5], rsp}, {2'b11, `SMCL_RESP_OKAY});
    axi_write(`SMCL_IDX_FEATURE_CFG, 8'h00, rsp);
    axi_write(`SMCL_IDX_BRIDGE_CONTROL, 8'h00, rsp);
    axi_write(`SMCL_IDX_LINK_CONTROL, 8'h20, rsp);
    axi_write(`SMCL_IDX_REMOTE_ADDR, 8'h5c, rsp);
    chk(cfg, {6'b000001, 8'h5c});
    axi_write(`SMCL_IDX_FEATURE_CFG, 8'ha2, rsp);
    chk(rsp, `SMCL_RESP_OKAY);
    axi_read(`SMCL_IDX_FEATURE_CFG, rd, rsp);
    chk(rd, 32'ha2);
    chk({cfg.external_control_bit, cfg.remote_copy, cfg.aux_audio}, 3'b111);
    // Low byte strobe off: write must leave the bits alone
    strb = 4'he;
    axi_write(`SMCL_IDX_FEATURE_CFG, 8'h00, rsp);
    strb = 4'hf;
    chk(rsp, `SMCL_RESP_OKAY);
    chk({cfg.external_control_bit, cfg.remote_copy, cfg.aux_audio}, 3'b111);
    axi_write(10'h3ff, 8'hff, rsp);
    chk(rsp, `SMCL_RESP_SLVERR);
    axi_read(10'h3ff, rd, rsp);
    chk(rd, 32'h0);
    chk(rsp, `SMCL_RESP_SLVERR);
    $display("test registers done");
  endtask

  task automatic t_pll();
    int k;
    for (k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      fdet <= 1'b1;
      @(posedge clk_sys);
      fdet <= 1'b0;
      @(posedge clk_sys);
      chk(pll_rst, k == 0);
      @(posedge clk_sys);
      chk(pll_rst, 0);
      axi_write(`SMCL_IDX_LINK_CONTROL, 8'h00, rsp);
    end
    $display("test pll reset done");
  endtask

  task automatic t_pclk();
    int k;
    logic [17:0] tv [4];
    tv = '{{1'b1, `SMCL_PCLK_MAX_NEW_KHZ}, {1'b1, `SMCL_PCLK_MAX_NEW_KHZ + 17'h1},
           {1'b0, `SMCL_PCLK_MAX_OLD_KHZ - 17'h1}, {1'b0, `SMCL_PCLK_MAX_OLD_KHZ}};
    for (k = 0; k < 4; k++) begin
      newgen <= tv[k][17];
      pclk <= tv[k][16:0];
      repeat (3) @(posedge clk_sys);
      chk(over, k[0]);
    end
    $display("test pixel clock done");
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    found = 1'b0;
    newgen = 1'b1;
    fdet = 1'b0;
    pclk = 17'h0;
    lv0 = 3'd0;
    lv1 = 3'd0;
    lva = 3'd0;
    m = '0;
    strb = 4'hf;
    n_mismatch = 0;
    check_count = 0;
    t_straps();
    t_regs();
    t_pll();
    t_pclk();
    test_done();
  end
endmodule

`default_nettype wire
